// >>> hdl/option_cfg_pkg.sv
package option_cfg_pkg;

  // ---------------------------------------------------------------------------
  // Register selects and byte width
  // ---------------------------------------------------------------------------
  localparam int unsigned BYTE_W          = 8;
  localparam logic        SEL_BYTE_ZERO   = 1'b0;
  localparam logic        SEL_BYTE_ONE    = 1'b1;

  // ---------------------------------------------------------------------------
  // Configuration byte one fields
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_SEL_HI      = 7;
  localparam int unsigned CLK_SEL_LO      = 6;
  localparam int unsigned B1_RSV_ONE      = 5;
  localparam int unsigned B1_RSV_ZERO     = 4;
  localparam int unsigned LVD_HI          = 3;
  localparam int unsigned LVD_LO          = 2;
  localparam int unsigned WATCHDOG_SOFTWARE_MODE_BIT      = 1;
  localparam int unsigned WDG_HALT_BIT    = 0;

  // ---------------------------------------------------------------------------
  // Configuration byte zero fields
  // ---------------------------------------------------------------------------
  localparam int unsigned SECTOR_BIT      = 2;
  localparam int unsigned RD_PROT_BIT     = 1;
  localparam int unsigned WR_PROT_BIT     = 0;

  // ---------------------------------------------------------------------------
  // Default and erased values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  BYTE_ZERO_RESET = 8'hf0;
  localparam logic [7:0]  BYTE_ONE_RESET  = 8'h2f;
  localparam logic [7:0]  ERASED_BYTE     = 8'hff;

  // ---------------------------------------------------------------------------
  // Decoded encodings
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  CLK_INT_RC      = 2'h0;
  localparam logic [1:0]  CLK_WAKE_RC     = 2'h1;
  localparam logic [1:0]  CLK_RESERVED    = 2'h2;
  localparam logic [1:0]  CLK_EXTERNAL    = 2'h3;
  localparam logic [1:0]  LVD_OFF         = 2'h3;

  typedef enum logic [1:0] {
    CLK_SRC_INT_RC,
    CLK_SRC_WAKE_RC,
    CLK_SRC_EXTERNAL
  } clk_src_e;

  typedef enum logic [1:0] {
    FL_IDLE,
    FL_MASS_ERASE,
    FL_BYTES_ERASE
  } flash_state_e;

endpackage : option_cfg_pkg

// >>> hdl/option_decode.sv
`timescale 1ns/1ns
module option_decode
  import option_cfg_pkg::*;
(
  input  wire logic [7:0] byte_zero_i,
  input  wire logic [7:0] byte_one_i,
  output clk_src_e        clk_src_o,
  output logic            lvd_enable_o,
  output logic [1:0]      lvd_level_o,
  output logic            wdg_hw_o,
  output logic            halt_reset_o,
  output logic            sector_large_o,
  output logic            rd_prot_o,
  output logic            wr_prot_o
);

  logic [1:0] clk_field;
  logic [1:0] lvd_field;

  assign clk_field = byte_one_i[CLK_SEL_HI:CLK_SEL_LO];
  assign lvd_field = byte_one_i[LVD_HI:LVD_LO];

  // Reserved code 10 falls back to the internal oscillator as a safe start.
  always_comb begin
    case (clk_field)
      CLK_INT_RC:   clk_src_o = CLK_SRC_INT_RC;
      CLK_WAKE_RC:  clk_src_o = CLK_SRC_WAKE_RC;
      CLK_EXTERNAL: clk_src_o = CLK_SRC_EXTERNAL;
      default:      clk_src_o = CLK_SRC_INT_RC;
    endcase
  end

  assign lvd_enable_o   = (lvd_field != LVD_OFF);
  assign lvd_level_o    = lvd_field;
  assign wdg_hw_o       = ~byte_one_i[WATCHDOG_SOFTWARE_MODE_BIT];
  assign halt_reset_o   = byte_one_i[WDG_HALT_BIT];
  assign sector_large_o = byte_zero_i[SECTOR_BIT];
  assign rd_prot_o      = byte_zero_i[RD_PROT_BIT];
  assign wr_prot_o      = byte_zero_i[WR_PROT_BIT];

endmodule : option_decode

// >>> hdl/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             mclk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] stage_a;
  logic [WIDTH-1:0] stage_b;
  logic [WIDTH-1:0] stage_c;

  // The third stage only confirms a change; the first is never looked at.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      stage_a <= '0;
      stage_b <= '0;
      stage_c <= '0;
      level_o <= '0;
    end else begin
      stage_a <= pin_i;
      stage_b <= stage_a;
      stage_c <= stage_b;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage_b[i] == stage_c[i]) begin
          level_o[i] <= stage_c[i];
        end
      end
    end
  end

endmodule : pin_sync

// >>> hdl/option_byte_config.sv
`timescale 1ns/1ns
module option_byte_config
  import option_cfg_pkg::*;
#(
  parameter int unsigned MEM_WORDS = 1024,
  parameter int unsigned ADDR_W    = 10
) (
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  input  wire logic              prog_mode_pin_i,
  input  wire logic              opt_sel_i,
  input  wire logic              opt_rd_i,
  input  wire logic              opt_wr_i,
  input  wire logic              opt_erase_i,
  input  wire logic [7:0]        opt_wdata_i,
  output logic      [7:0]        opt_rdata_o,
  output logic                   opt_ack_o,
  output logic                   opt_refused_o,
  input  wire logic              mem_rd_i,
  input  wire logic              mem_wr_i,
  input  wire logic              mem_erase_i,
  input  wire logic [ADDR_W-1:0] mem_addr_i,
  input  wire logic [7:0]        mem_wdata_i,
  output logic      [7:0]        mem_rdata_o,
  output logic                   mem_ack_o,
  output logic                   mem_refused_o,
  output logic                   busy_o,
  input  wire logic              wdg_active_i,
  input  wire logic              halt_enter_i,
  output logic                   halt_reset_req_o,
  output clk_src_e               clk_src_o,
  output logic                   lvd_enable_o,
  output logic      [1:0]        lvd_level_o,
  output logic                   wdg_hw_enable_o,
  output logic                   sector_large_o,
  output logic                   readout_protect_o,
  output logic                   write_protect_permanent_o
);

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  if (MEM_WORDS < 2 || MEM_WORDS > (1 << ADDR_W)) begin : g_bad_size
    $error("MEM_WORDS does not fit ADDR_W");
  end

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [7:0]        config_byte_zero;
  logic [7:0]        config_byte_one;
  logic [7:0]        prog_mem [MEM_WORDS];
  logic              prog_mode;
  flash_state_e      fl_state;
  logic [ADDR_W-1:0] erase_idx;
  logic              erase_last;

  // Settings latched at reset; the live bytes may change under the tool.
  logic [7:0]        held_zero;
  logic [7:0]        held_one;
  logic              capture_pending;

  // Remembers that the mass erase was started by an option erase.
  logic              opt_pending;

  pin_sync #(
    .WIDTH   (1)
  ) u_prog_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .pin_i   (prog_mode_pin_i),
    .level_o (prog_mode)
  );

  function automatic logic fits_mem(input logic [ADDR_W-1:0] addr);
    fits_mem = (int'(addr) < MEM_WORDS);
  endfunction : fits_mem

  // ---------------------------------------------------------------------------
  // Access qualification
  // ---------------------------------------------------------------------------
  logic idle;
  logic wp;
  logic rp;
  logic opt_rd_ok;
  logic opt_wr_ok;
  logic opt_er_ok;
  logic mem_rd_ok;
  logic mem_wr_ok;
  logic mem_er_ok;
  logic opt_any;
  logic mem_any;

  assign idle      = (fl_state == FL_IDLE);
  // Protection follows the bytes sampled at reset, so an erase to ff does
  // not lock the tool out before it has written the new bytes.
  assign wp        = held_zero[WR_PROT_BIT];
  assign rp        = held_zero[RD_PROT_BIT];
  assign opt_any   = opt_rd_i | opt_wr_i | opt_erase_i;
  assign mem_any   = mem_rd_i | mem_wr_i | mem_erase_i;
  assign opt_rd_ok = opt_rd_i & prog_mode & idle;
  assign opt_wr_ok = opt_wr_i & ~opt_rd_i & prog_mode & idle & ~wp;
  assign opt_er_ok = opt_erase_i & ~opt_rd_i & ~opt_wr_i
                   & prog_mode & idle & ~wp;
  assign mem_rd_ok = mem_rd_i & prog_mode & idle & ~rp
                   & fits_mem(mem_addr_i);
  assign mem_wr_ok = mem_wr_i & ~mem_rd_i & prog_mode & idle & ~rp & ~wp
                   & fits_mem(mem_addr_i);
  assign mem_er_ok = mem_erase_i & ~mem_rd_i & ~mem_wr_i
                   & prog_mode & idle & ~rp & ~wp;
  assign erase_last = (int'(erase_idx) == MEM_WORDS - 1);
  assign busy_o     = ~idle;

  // ---------------------------------------------------------------------------
  // Erase sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      fl_state  <= FL_IDLE;
      erase_idx <= '0;
    end else begin
      case (fl_state)
        FL_IDLE: begin
          erase_idx <= '0;
          if (opt_er_ok && rp) begin
            fl_state <= FL_MASS_ERASE;
          end else if (opt_er_ok || mem_er_ok) begin
            fl_state <= mem_er_ok ? FL_MASS_ERASE : FL_BYTES_ERASE;
          end
        end
        FL_MASS_ERASE: begin
          erase_idx <= erase_idx + 1'b1;
          if (erase_last) begin
            fl_state <= opt_pending ? FL_BYTES_ERASE : FL_IDLE;
          end
        end
        FL_BYTES_ERASE: begin
          fl_state <= FL_IDLE;
        end
        default: begin
          fl_state <= FL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      opt_pending <= 1'b0;
    end else if (idle) begin
      opt_pending <= opt_er_ok;
    end else if (fl_state == FL_BYTES_ERASE) begin
      opt_pending <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Program memory, erased at reset so parts start blank
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      for (int i = 0; i < MEM_WORDS; i++) begin
        prog_mem[i] <= ERASED_BYTE;
      end
    end else if (fl_state == FL_MASS_ERASE) begin
      prog_mem[erase_idx] <= ERASED_BYTE;
    end else if (mem_wr_ok) begin
      // Flash only clears bits; returning to one needs an erase.
      prog_mem[mem_addr_i] <= prog_mem[mem_addr_i] & mem_wdata_i;
    end
  end

  // ---------------------------------------------------------------------------
  // Option bytes; non-volatile contents are modelled as surviving every reset after the first
  // ---------------------------------------------------------------------------
  // Power-on state of the non-volatile marker; no reset may clear it.
  logic bytes_init = 1'b0;

  always_ff @(posedge mclk_i) begin
    if (reset_i && !bytes_init) begin
      config_byte_zero <= BYTE_ZERO_RESET;
      config_byte_one  <= BYTE_ONE_RESET;
    end else if (!reset_i && fl_state == FL_BYTES_ERASE) begin
      config_byte_zero <= ERASED_BYTE;
      config_byte_one  <= ERASED_BYTE;
    end else if (!reset_i && opt_wr_ok) begin
      // The tool is trusted to set the reserved bits correctly.
      if (opt_sel_i == SEL_BYTE_ZERO) begin
        config_byte_zero <= opt_wdata_i;
      end else begin
        config_byte_one  <= opt_wdata_i;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      bytes_init <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Tool answers
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      opt_rdata_o   <= 8'h00;
      opt_ack_o     <= 1'b0;
      opt_refused_o <= 1'b0;
    end else begin
      opt_ack_o     <= opt_rd_ok | opt_wr_ok | opt_er_ok;
      opt_refused_o <= opt_any & ~(opt_rd_ok | opt_wr_ok | opt_er_ok);
      if (opt_rd_ok) begin
        opt_rdata_o <= (opt_sel_i == SEL_BYTE_ONE) ? config_byte_one
                                                   : config_byte_zero;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mem_rdata_o   <= 8'h00;
      mem_ack_o     <= 1'b0;
      mem_refused_o <= 1'b0;
    end else begin
      mem_ack_o     <= mem_rd_ok | mem_wr_ok | mem_er_ok;
      mem_refused_o <= mem_any & ~(mem_rd_ok | mem_wr_ok | mem_er_ok);
      if (mem_rd_ok) begin
        mem_rdata_o <= prog_mem[mem_addr_i];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Settings capture at the end of reset
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      capture_pending <= 1'b1;
      held_zero       <= BYTE_ZERO_RESET;
      held_one        <= BYTE_ONE_RESET;
    end else if (capture_pending) begin
      capture_pending <= 1'b0;
      held_zero       <= config_byte_zero;
      held_one        <= config_byte_one;
    end
  end

  clk_src_e   dec_clk;
  logic       dec_lvd_en;
  logic [1:0] dec_lvd_lvl;
  logic       dec_wdg_hw;
  logic       dec_halt_rst;
  logic       dec_sector;
  logic       dec_rp;
  logic       dec_wp;

  option_decode u_decode (
    .byte_zero_i    (held_zero),
    .byte_one_i     (held_one),
    .clk_src_o      (dec_clk),
    .lvd_enable_o   (dec_lvd_en),
    .lvd_level_o    (dec_lvd_lvl),
    .wdg_hw_o       (dec_wdg_hw),
    .halt_reset_o   (dec_halt_rst),
    .sector_large_o (dec_sector),
    .rd_prot_o      (dec_rp),
    .wr_prot_o      (dec_wp)
  );

  // ---------------------------------------------------------------------------
  // Distributed settings, registered
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      clk_src_o                 <= CLK_SRC_INT_RC;
      lvd_enable_o              <= 1'b0;
      lvd_level_o               <= LVD_OFF;
      wdg_hw_enable_o           <= 1'b0;
      sector_large_o            <= 1'b0;
      readout_protect_o         <= 1'b0;
      write_protect_permanent_o <= 1'b0;
    end else begin
      clk_src_o                 <= dec_clk;
      lvd_enable_o              <= dec_lvd_en;
      lvd_level_o               <= dec_lvd_lvl;
      wdg_hw_enable_o           <= dec_wdg_hw;
      sector_large_o            <= dec_sector;
      readout_protect_o         <= dec_rp;
      write_protect_permanent_o <= dec_wp;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      halt_reset_req_o <= 1'b0;
    end else begin
      halt_reset_req_o <= halt_enter_i & wdg_active_i & dec_halt_rst
                        & ~capture_pending;
    end
  end

endmodule : option_byte_config

// >>> bench/option_byte_config_sva.sv
`timescale 1ns/1ns
module option_byte_config_sva
  import option_cfg_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       reset_i,
  input wire logic       prog_mode_pin_i,
  input wire logic       opt_rd_i,
  input wire logic       opt_ack_o,
  input wire logic       opt_refused_o,
  input wire logic       mem_rd_i,
  input wire logic       mem_wr_i,
  input wire logic       mem_ack_o,
  input wire logic       mem_refused_o,
  input wire logic       busy_o,
  input wire logic       wdg_active_i,
  input wire logic       halt_enter_i,
  input wire logic       halt_reset_req_o,
  input wire clk_src_e   clk_src_o,
  input wire logic       lvd_enable_o,
  input wire logic [1:0] lvd_level_o,
  input wire logic       readout_protect_o,
  input wire logic       write_protect_permanent_o
);
  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  // Outputs settle on the second edge after release, so wait four.
  sequence settled_s;
    (!reset_i) [*4];
  endsequence
  sequence halt_cause_s;
    halt_enter_i && wdg_active_i;
  endsequence

  chk_reset_values: assert property ($fell(reset_i) |->
    clk_src_o == CLK_SRC_INT_RC && lvd_level_o == LVD_OFF && !busy_o)
    else $error("outputs wrong right after reset");
  chk_settings_hold: assert property (settled_s |->
    $stable(clk_src_o) && $stable(lvd_level_o) &&
    $stable(readout_protect_o) && $stable(write_protect_permanent_o))
    else $error("settings changed during operation");
  chk_lvd_enable: assert property (settled_s |->
    lvd_enable_o == (lvd_level_o != LVD_OFF))
    else $error("detector enable disagrees with level");
  chk_halt_cause: assert property (halt_reset_req_o |->
    $past(halt_enter_i) && $past(wdg_active_i))
    else $error("halt reset without halt and watchdog");
  chk_no_prog: assert property ((!prog_mode_pin_i) [*6] ##0 opt_rd_i |=>
    opt_refused_o && !opt_ack_o)
    else $error("option read accepted outside programming");
  chk_answer_excl: assert property (!(opt_ack_o && opt_refused_o) &&
    !(mem_ack_o && mem_refused_o))
    else $error("accept and refuse together");
  chk_busy_refuse: assert property (busy_o && opt_rd_i |=> opt_refused_o)
    else $error("request accepted while erasing");
  chk_rprot_block: assert property (readout_protect_o &&
    (mem_rd_i || mem_wr_i) |=> mem_refused_o && !mem_ack_o)
    else $error("memory access under read protection");
  chk_wprot_block: assert property (write_protect_permanent_o &&
    mem_wr_i |=> mem_refused_o)
    else $error("memory write under write protection");
  cover property (halt_cause_s ##1 halt_reset_req_o);
endmodule : option_byte_config_sva

// >>> bench/prog_tool_model.sv
`timescale 1ns/1ns
module prog_tool_model (
  input  wire logic       mclk_i,
  input  wire logic       opt_ack_i,
  input  wire logic       opt_refused_i,
  input  wire logic [7:0] opt_rdata_i,
  input  wire logic       mem_ack_i,
  input  wire logic       mem_refused_i,
  input  wire logic [7:0] mem_rdata_i,
  output logic            prog_mode_o,
  output logic            opt_sel_o,
  output logic            opt_rd_o,
  output logic            opt_wr_o,
  output logic            opt_erase_o,
  output logic      [7:0] opt_wdata_o,
  output logic            mem_rd_o,
  output logic            mem_wr_o,
  output logic            mem_erase_o,
  output logic      [3:0] mem_addr_o,
  output logic      [7:0] mem_wdata_o
);
  initial begin
    {prog_mode_o, opt_sel_o, opt_rd_o, opt_wr_o, opt_erase_o} = 5'h0;
    {mem_rd_o, mem_wr_o, mem_erase_o, mem_addr_o} = 7'h0;
    {opt_wdata_o, mem_wdata_o} = 16'h0;
  end

  // The tool sets the mode pin level; the bytes accept option requests only while it is raised.
  task automatic set_prog(input logic v);
    @(posedge mclk_i);
    #1;
    prog_mode_o = v;
  endtask : set_prog

  // Kind 0 reads, 1 writes, 2 erases; one request, answer a cycle later.
  task automatic op(input logic mem, input logic [1:0] kind,
                    input logic [3:0] adr, input logic [7:0] dat,
                    output logic [1:0] ans, output logic [7:0] rd);
    @(posedge mclk_i);
    #1;
    opt_sel_o   = adr[0];
    mem_addr_o  = adr;
    mem_wdata_o = dat;
    opt_wdata_o = adr[0] ? (dat | 8'h20) & 8'hef
                         : (dat | 8'hf0) & 8'hf7;
    {opt_rd_o, opt_wr_o, opt_erase_o} = mem ? 3'h0 : 3'h4 >> kind;
    {mem_rd_o, mem_wr_o, mem_erase_o} = mem ? 3'h4 >> kind : 3'h0;
    @(posedge mclk_i);
    #1;
    {opt_rd_o, opt_wr_o, opt_erase_o, mem_rd_o, mem_wr_o, mem_erase_o} = 6'h0;
    // Released lines show garbage, not the last value.
    {opt_sel_o, mem_addr_o} = ~{opt_sel_o, mem_addr_o};
    {opt_wdata_o, mem_wdata_o} = ~{opt_wdata_o, mem_wdata_o};
    ans = mem ? {mem_ack_i, mem_refused_i} : {opt_ack_i, opt_refused_i};
    rd  = mem ? mem_rdata_i : opt_rdata_i;
  endtask : op
endmodule : prog_tool_model

// >>> bench/tb.sv
`timescale 1ns/1ns
module tb;
  import option_cfg_pkg::*;
  localparam int unsigned W = 16;
  logic mclk_i = 0, reset_i = 1, wdg_act = 0, halt_in = 0;
  logic prog, sel, o_rd, o_wr, o_er, m_rd, m_wr, m_er, o_ack, o_ref;
  logic m_ack, m_ref, busy, halt_req, lvd_en, wdg_hw, sect, rprot, wprot;
  logic [7:0] o_wd, o_rdat, m_wd, m_rdat, rd;
  logic [3:0] m_adr;
  logic [1:0] lvd_lvl, ans;
  clk_src_e   clk_src;
  int         n_errors = 0, check_count = 0;

  always #5 mclk_i = ~mclk_i;

  option_byte_config #(.MEM_WORDS(W), .ADDR_W(4)) i_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .prog_mode_pin_i(prog),
    .opt_sel_i(sel), .opt_rd_i(o_rd), .opt_wr_i(o_wr), .opt_erase_i(o_er),
    .opt_wdata_i(o_wd), .opt_rdata_o(o_rdat), .opt_ack_o(o_ack),
    .opt_refused_o(o_ref), .mem_rd_i(m_rd), .mem_wr_i(m_wr),
    .mem_erase_i(m_er), .mem_addr_i(m_adr), .mem_wdata_i(m_wd),
    .mem_rdata_o(m_rdat), .mem_ack_o(m_ack), .mem_refused_o(m_ref),
    .busy_o(busy), .wdg_active_i(wdg_act), .halt_enter_i(halt_in),
    .halt_reset_req_o(halt_req), .clk_src_o(clk_src),
    .lvd_enable_o(lvd_en), .lvd_level_o(lvd_lvl), .wdg_hw_enable_o(wdg_hw),
    .sector_large_o(sect), .readout_protect_o(rprot),
    .write_protect_permanent_o(wprot));

  prog_tool_model i_tool (
    .mclk_i(mclk_i), .opt_ack_i(o_ack), .opt_refused_i(o_ref),
    .opt_rdata_i(o_rdat), .mem_ack_i(m_ack), .mem_refused_i(m_ref),
    .mem_rdata_i(m_rdat), .prog_mode_o(prog), .opt_sel_o(sel),
    .opt_rd_o(o_rd), .opt_wr_o(o_wr), .opt_erase_o(o_er),
    .opt_wdata_o(o_wd), .mem_rd_o(m_rd), .mem_wr_o(m_wr),
    .mem_erase_o(m_er), .mem_addr_o(m_adr), .mem_wdata_o(m_wd));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", what, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // A short reset; the bytes survive it, the outputs reload from them.
  task automatic do_reset();
    @(posedge mclk_i);
    #1;
    reset_i = 1;
    repeat (2) @(posedge mclk_i);
    #1;
    reset_i = 0;
    repeat (8) @(posedge mclk_i);
    #1;
  endtask : do_reset

  task automatic wait_idle(output int k);
    k = 0;
    while (busy !== 1'b0 && k < 40) begin
      @(posedge mclk_i);
      #1;
      k++;
    end
  endtask : wait_idle

  task automatic halt_chk(input logic e);
    wdg_act = 1;
    halt_in = 1;
    @(posedge mclk_i);
    #1;
    chk("halt reset", 8'(e), 8'(halt_req));
    {wdg_act, halt_in} = 2'h0;
    @(posedge mclk_i);
    #1;
  endtask : halt_chk

  task automatic prog_bytes(input logic [7:0] b0, input logic [7:0] b1);
    int k;
    i_tool.op(0, 2, 4'h0, 8'h00, ans, rd);
    wait_idle(k);
    i_tool.op(0, 1, 4'h0, b0, ans, rd);
    i_tool.op(0, 1, 4'h1, b1, ans, rd);
    i_tool.op(0, 0, 4'h0, 8'h00, ans, rd);
    chk("byte zero", b0, rd);
    i_tool.op(0, 0, 4'h1, 8'h00, ans, rd);
    chk("byte one", b1, rd);
    do_reset();
  endtask : prog_bytes

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_no_prog();
    i_tool.op(0, 0, 4'h1, 8'h00, ans, rd);
    chk("option read outside mode", 8'h1, 8'(ans));
    i_tool.op(0, 1, 4'h0, 8'hf0, ans, rd);
    chk("option write outside mode", 8'h1, 8'(ans));
    i_tool.op(1, 0, 4'h3, 8'h00, ans, rd);
    chk("memory read outside mode", 8'h1, 8'(ans));
  endtask : t_no_prog

  task automatic t_defaults();
    chk("clock source", 8'(CLK_SRC_INT_RC), 8'(clk_src));
    chk("detector", 8'h03, {5'h0, lvd_en, lvd_lvl});
    chk("watchdog hw", 8'h00, 8'(wdg_hw));
    chk("protects", 8'h00, {5'h0, sect, rprot, wprot});
    halt_chk(1'b1);
    i_tool.op(1, 0, 4'h5, 8'h00, ans, rd);
    chk("erased memory", ERASED_BYTE, rd);
    i_tool.op(1, 1, 4'h2, 8'h0f, ans, rd);
    i_tool.op(1, 0, 4'h2, 8'h00, ans, rd);
    chk("memory write", 8'h0f, rd);
  endtask : t_defaults

  task automatic t_table();
    logic [1:0] i;
    clk_src_e   ec;
    for (int n = 0; n < 4; n++) begin
      i = 2'(n);
      ec = (i == 2'h1) ? CLK_SRC_WAKE_RC :
           (i == 2'h3) ? CLK_SRC_EXTERNAL : CLK_SRC_INT_RC;
      prog_bytes({5'h1e, i[0], 2'h0}, {i, 2'h2, i, i[0], i[1]});
      chk("clock source", 8'(ec), 8'(clk_src));
      chk("detector", {5'h0, i != 2'h3, i}, {5'h0, lvd_en, lvd_lvl});
      chk("watchdog hw", 8'(!i[0]), 8'(wdg_hw));
      chk("sector size", 8'(i[0]), 8'(sect));
      halt_chk(i[1]);
    end
  endtask : t_table

  task automatic t_rprot();
    int k;
    prog_bytes(8'hf2, 8'h2f);
    chk("read protect", 8'h01, 8'(rprot));
    i_tool.op(1, 0, 4'h1, 8'h00, ans, rd);
    chk("protected read", 8'h1, 8'(ans));
    i_tool.op(1, 1, 4'h1, 8'h00, ans, rd);
    chk("protected write", 8'h1, 8'(ans));
    i_tool.op(0, 2, 4'h0, 8'h00, ans, rd);
    chk("erase accepted", 8'h2, 8'(ans));
    i_tool.op(0, 0, 4'h0, 8'h00, ans, rd);
    chk("read while busy", 8'h1, 8'(ans));
    wait_idle(k);
    chk("erase cycles", 8'(W + 1), 8'(k + 2));
    i_tool.op(0, 0, 4'h0, 8'h00, ans, rd);
    chk("erased byte", ERASED_BYTE, rd);
  endtask : t_rprot

  task automatic t_wprot();
    prog_bytes(8'hf1, 8'h2f);
    chk("write protect", 8'h01, 8'(wprot));
    i_tool.op(0, 2, 4'h0, 8'h00, ans, rd);
    chk("option erase", 8'h1, 8'(ans));
    i_tool.op(0, 1, 4'h0, 8'hf0, ans, rd);
    chk("option write", 8'h1, 8'(ans));
    i_tool.op(1, 1, 4'h4, 8'h00, ans, rd);
    chk("memory write", 8'h1, 8'(ans));
    i_tool.op(1, 2, 4'h0, 8'h00, ans, rd);
    chk("memory erase", 8'h1, 8'(ans));
  endtask : t_wprot

  initial begin
    #100000;
    n_errors++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge mclk_i);
    #1;
    reset_i = 0;
    repeat (8) @(posedge mclk_i);
    t_no_prog();
    i_tool.set_prog(1'b1);
    repeat (8) @(posedge mclk_i);
    #1;
    t_defaults();
    t_table();
    t_rprot();
    t_wprot();
    test_done();
  end
endmodule : tb

bind option_byte_config option_byte_config_sva i_chk (
  .mclk_i(mclk_i), .reset_i(reset_i), .prog_mode_pin_i(prog_mode_pin_i),
  .opt_rd_i(opt_rd_i), .opt_ack_o(opt_ack_o),
  .opt_refused_o(opt_refused_o), .mem_rd_i(mem_rd_i), .mem_wr_i(mem_wr_i),
  .mem_ack_o(mem_ack_o), .mem_refused_o(mem_refused_o), .busy_o(busy_o),
  .wdg_active_i(wdg_active_i), .halt_enter_i(halt_enter_i),
  .halt_reset_req_o(halt_reset_req_o), .clk_src_o(clk_src_o),
  .lvd_enable_o(lvd_enable_o), .lvd_level_o(lvd_level_o),
  .readout_protect_o(readout_protect_o),
  .write_protect_permanent_o(write_protect_permanent_o));
